// [pkg/prsl_pkg.sv]
package prsl_pkg;
    // register byte offsets
    localparam logic [7:0] PRSL_OFS_RATIO0 = 8'h00;
    localparam logic [7:0] PRSL_OFS_RATIO1 = 8'h04;
    localparam logic [7:0] PRSL_OFS_RATIO2 = 8'h08;
    localparam logic [7:0] PRSL_OFS_RATIO3 = 8'h0c;
    localparam logic [7:0] PRSL_OFS_GLOBAL = 8'h10;
    localparam logic [7:0] PRSL_OFS_MODAL  = 8'h14;
    localparam logic [7:0] PRSL_OFS_STATUS = 8'h18;
    localparam logic [7:0] PRSL_OFS_EFF    = 8'h1c;
    // global field positions
    localparam int PRSL_GLB_FMT  = 0;
    localparam int PRSL_GLB_AUXF = 1;
    localparam int PRSL_GLB_UNL  = 4;
    localparam int PRSL_GLB_RDIV = 5;
    localparam int PRSL_MODAL_W  = 3;
    // reset values
    localparam logic [31:0] PRSL_RATIO_RST = 32'h0010_0000;
    localparam logic [6:0]  PRSL_GLB_RST   = 7'h00;
    localparam logic [2:0]  PRSL_MODAL_RST = 3'h0;
    // aux pin function codes
    localparam logic [2:0] PRSL_AUXF_OD_SYNTH = 3'h0;
    localparam logic [2:0] PRSL_AUXF_OD_BOTH  = 3'h2;
    localparam logic [2:0] PRSL_AUXF_MANUAL   = 3'h3;
    localparam logic [2:0] PRSL_AUXF_AUTO     = 3'h5;
    // range detector
    localparam int          PRSL_CNT_W     = 8;
    localparam logic [7:0]  PRSL_RANGE_HI  = 8'he0;
    localparam logic [7:0]  PRSL_RANGE_LO  = 8'h60;
    localparam logic [1:0]  PRSL_CODE_FAST = 2'h0;
    localparam logic [1:0]  PRSL_CODE_MID  = 2'h1;
    localparam logic [1:0]  PRSL_CODE_SLOW = 2'h2;
    localparam logic        PRSL_RESP_OKAY = 1'b0;

    typedef struct packed {
        logic [1:0] ref_div;
        logic       out_unl;
        logic [2:0] aux_func;
        logic       fmt;
    } prsl_global_t;

    typedef struct packed {
        logic       auto_en;
        logic [1:0] man_sel;
    } prsl_modal_t;

    typedef struct packed {
        logic [31:0] ratio;
        logic        fmt;
        logic [1:0]  ref_div;
        logic [19:0] int_part;
        logic [19:0] frac_part;
    } prsl_ratio_out_t;

    typedef struct packed {
        logic       valid;
        logic       wr;
        logic [7:0] addr;
    } prsl_ahb_ap_t;
endpackage

// [rtl/prsl_sync2.sv]
`timescale 1ns/10ps
module prsl_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    always_comb begin
        meta_d = d;
        q_d    = meta_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= meta_d;
            q      <= q_d;
        end
    end
endmodule

// [rtl/prsl_range_det.sv]
`timescale 1ns/10ps
module prsl_range_det
    import prsl_pkg::*;
(
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // synchronised frequency reference level
    input  wire logic       ref_level,
    // measured range
    output logic      [1:0] range_code
);
    logic                  dly_q, dly_d;
    logic [PRSL_CNT_W-1:0] cnt_q, cnt_d;
    logic [1:0]            code_d;
    logic                  edge_w;

    assign edge_w = ref_level & ~dly_q;

    // saturating count is enough: anything past the upper bound is one class
    always_comb begin
        dly_d  = ref_level;
        cnt_d  = (&cnt_q) ? cnt_q : cnt_q + 8'h01;
        code_d = range_code;
        if (edge_w) begin
            cnt_d = 8'h01;
            if (cnt_q > PRSL_RANGE_HI)
                code_d = PRSL_CODE_FAST;
            else if (cnt_q >= PRSL_RANGE_LO)
                code_d = PRSL_CODE_MID;
            else
                code_d = PRSL_CODE_SLOW;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dly_q      <= 1'b0;
            cnt_q      <= '0;
            range_code <= PRSL_CODE_FAST;
        end else begin
            dly_q      <= dly_d;
            cnt_q      <= cnt_d;
            range_code <= code_d;
        end
    end

    sequence s_edge_cnt_above;
        edge_w && cnt_q > 8'he0;
    endsequence
    property p_code_fast;
        @(posedge hclk) disable iff (!hresetn)
        s_edge_cnt_above |=> range_code == 2'h0;
    endproperty
    a_code_fast: assert property (p_code_fast) else $error("fast range code wrong");
    property p_code_mid;
        @(posedge hclk) disable iff (!hresetn)
        (edge_w && cnt_q >= 8'h60 && cnt_q <= 8'he0) |=> range_code == 2'h1;
    endproperty
    a_code_mid: assert property (p_code_mid) else $error("mid range code wrong");
    property p_code_slow;
        @(posedge hclk) disable iff (!hresetn)
        (edge_w && cnt_q < 8'h60) |=> range_code == 2'h2;
    endproperty
    a_code_slow: assert property (p_code_slow) else $error("slow range code wrong");
    property p_code_hold;
        @(posedge hclk) disable iff (!hresetn)
        !edge_w |=> $stable(range_code);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("range code moved without edge");
endmodule

// [rtl/prsl_top.sv]
// Operation
// - user ratio is 32-bit unsigned fixed point
// - four stored ratios, picked by select pins
// - global format bit picks 12.20 or 20.12
// - 12.20: 12 integer, 20 fraction bits
// - 20.12: 20 integer, 12 fraction bits
// - internal dividers handled, ratio is plain
// - modifiers never alter the stored ratios
// - manual modifier enabled only through aux pin
// - manual factors 0.5, 0.25, 0.125, 0.0625
// - range detector reports two-bit range code
// - code 00 x1, 01 x0.5, 10 x0.25
// - auto modifier enabled by modal bit or pin
// - auto factor stacks on manual factor
// - effective ratio is product of all three
// - select pins pick ratio and modal set
// - aux pin tristates output for 000/010
// - output held low while unlocked
// - output-on-unlock lets clock pass anyway
// - manual modifier is right shift 1..4
// - manual active: aux pin high, function 011
// - function 101: aux pin overrides auto enable
// - output disable: high disables, low enables
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module prsl_top
    import prsl_pkg::*;
(
    // clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // ahb-lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    // mode pins and frequency reference
    input  wire logic [1:0]      ratio_select_pins,
    input  wire logic            aux_mode_pin,
    input  wire logic            freq_ref_in,
    // synthesizer side
    input  wire logic            loop_locked,
    input  wire logic            synth_clk_in,
    output logic                 synth_clk_out,
    output logic                 synth_clk_oe,
    output prsl_ratio_out_t      ratio_out,
    output logic                 ratio_changed
);
    // synchronised pins
    logic [4:0]            pins_s;
    logic [1:0]            mode_s;
    logic                  aux_s;
    logic                  ref_s;
    logic                  locked_s;
    logic [1:0]            range_code;

    // bus state
    prsl_ahb_ap_t          ap_q, ap_d;
    logic [31:0]           rd_q, rd_d;
    logic                  wr_en;
    logic                  rd_req;

    // configuration storage
    logic [31:0]           ratio_q [4];
    logic [31:0]           ratio_d [4];
    prsl_global_t          glob_q, glob_d;
    prsl_modal_t           modal_q [4];
    prsl_modal_t           modal_d [4];

    // ratio path
    prsl_modal_t           modal_sel;
    logic [31:0]           sel_ratio;
    logic                  man_act;
    logic                  auto_act;
    logic [2:0]            man_shift;
    logic [2:0]            auto_shift;
    logic [31:0]           eff_d;
    prsl_ratio_out_t       out_d;
    logic                  chg_d;

    // output control
    logic                  gate_q, gate_d;
    logic                  oe_q, oe_d;
    logic [31:0]           status_w;

    prsl_sync2 #(
        .W (5)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({ratio_select_pins, aux_mode_pin, freq_ref_in, loop_locked}),
        .q       (pins_s)
    );

    assign mode_s   = pins_s[4:3];
    assign aux_s    = pins_s[2];
    assign ref_s    = pins_s[1];
    assign locked_s = pins_s[0];

    prsl_range_det u_range (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .ref_level  (ref_s),
        .range_code (range_code)
    );

    // zero wait states, so the slave never stalls the bus
    assign hreadyout = 1'b1;
    assign hresp     = PRSL_RESP_OKAY;
    assign hrdata    = rd_q;

    assign rd_req = hsel & htrans[1] & hready & ~hwrite;
    assign wr_en  = ap_q.valid & ap_q.wr;

    // only whole-word transfers exist, so hsize is not decoded
    always_comb begin
        ap_d.valid = hsel & htrans[1] & hready;
        ap_d.wr    = hwrite;
        ap_d.addr  = haddr[7:0];
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ratio_d[i] = ratio_q[i];
            modal_d[i] = modal_q[i];
        end
        glob_d = glob_q;
        if (wr_en) begin
            case (ap_q.addr)
                PRSL_OFS_RATIO0: ratio_d[0] = hwdata;
                PRSL_OFS_RATIO1: ratio_d[1] = hwdata;
                PRSL_OFS_RATIO2: ratio_d[2] = hwdata;
                PRSL_OFS_RATIO3: ratio_d[3] = hwdata;
                PRSL_OFS_GLOBAL: begin
                    glob_d.fmt      = hwdata[PRSL_GLB_FMT];
                    glob_d.aux_func = hwdata[PRSL_GLB_AUXF +: 3];
                    glob_d.out_unl  = hwdata[PRSL_GLB_UNL];
                    glob_d.ref_div  = hwdata[PRSL_GLB_RDIV +: 2];
                end
                PRSL_OFS_MODAL: begin
                    for (int i = 0; i < 4; i++) begin
                        modal_d[i] = hwdata[PRSL_MODAL_W*i +: PRSL_MODAL_W];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q   <= '0;
            glob_q <= PRSL_GLB_RST;
            for (int i = 0; i < 4; i++) begin
                ratio_q[i] <= PRSL_RATIO_RST;
                modal_q[i] <= PRSL_MODAL_RST;
            end
        end else begin
            ap_q   <= ap_d;
            glob_q <= glob_d;
            for (int i = 0; i < 4; i++) begin
                ratio_q[i] <= ratio_d[i];
                modal_q[i] <= modal_d[i];
            end
        end
    end

    assign status_w = {23'h0, oe_q, gate_q, locked_s, auto_act,
                       man_act, mode_s, range_code};

    // reads look at the _d copies so a write just before is seen
    always_comb begin
        rd_d = rd_q;
        if (rd_req) begin
            case (haddr[7:0])
                PRSL_OFS_RATIO0: rd_d = ratio_d[0];
                PRSL_OFS_RATIO1: rd_d = ratio_d[1];
                PRSL_OFS_RATIO2: rd_d = ratio_d[2];
                PRSL_OFS_RATIO3: rd_d = ratio_d[3];
                PRSL_OFS_GLOBAL: rd_d = {25'h0, glob_d};
                PRSL_OFS_MODAL:  rd_d = {20'h0, modal_d[3], modal_d[2],
                                         modal_d[1], modal_d[0]};
                PRSL_OFS_STATUS: rd_d = status_w;
                PRSL_OFS_EFF:    rd_d = ratio_out.ratio;
                default:         rd_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 32'h0;
        end else begin
            rd_q <= rd_d;
        end
    end

    // one pin pair picks both the ratio and the modal set
    assign sel_ratio = ratio_q[mode_s];
    assign modal_sel = modal_q[mode_s];

    // modifiers act on this copy only; storage is never rewritten here
    always_comb begin
        man_act = aux_s && (glob_q.aux_func == PRSL_AUXF_MANUAL);
        if (glob_q.aux_func == PRSL_AUXF_AUTO)
            auto_act = aux_s;
        else
            auto_act = modal_sel.auto_en;
        man_shift = man_act ? {1'b0, modal_sel.man_sel} + 3'h1 : 3'h0;
        auto_shift = 3'h0;
        if (auto_act) begin
            unique case (range_code)
                PRSL_CODE_MID:  auto_shift = 3'h1;
                PRSL_CODE_SLOW: auto_shift = 3'h2;
                default:        auto_shift = 3'h0;
            endcase
        end
        // shifts add, so the factors multiply; low bits fall off (caller's care)
        eff_d = sel_ratio >> (man_shift + auto_shift);
    end

    // the loop side corrects for the reference divider using ref_div
    always_comb begin
        out_d.ratio   = eff_d;
        out_d.fmt     = glob_q.fmt;
        out_d.ref_div = glob_q.ref_div;
        if (glob_q.fmt) begin
            out_d.int_part  = eff_d[31:12];
            out_d.frac_part = {eff_d[11:0], 8'h00};
        end else begin
            out_d.int_part  = {8'h00, eff_d[31:20]};
            out_d.frac_part = eff_d[19:0];
        end
        chg_d = (out_d.ratio != ratio_out.ratio);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ratio_out     <= '0;
            ratio_changed <= 1'b0;
        end else begin
            ratio_out     <= out_d;
            ratio_changed <= chg_d;
        end
    end

    // gate toggles asynchronously to the synthesizer clock; the analog side
    // is expected to stop its clock low around lock changes
    always_comb begin
        gate_d = locked_s | glob_q.out_unl;
        oe_d   = ~(aux_s && ((glob_q.aux_func == PRSL_AUXF_OD_SYNTH) ||
                             (glob_q.aux_func == PRSL_AUXF_OD_BOTH)));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_q <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            gate_q <= gate_d;
            oe_q   <= oe_d;
        end
    end

    assign synth_clk_out = synth_clk_in & gate_q;
    assign synth_clk_oe  = oe_q;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic [127:0] ratio_flat;
    assign ratio_flat = {ratio_q[3], ratio_q[2], ratio_q[1], ratio_q[0]};

    property p_sel_plain;
        (!man_act && !auto_act) |=> ratio_out.ratio == $past(sel_ratio);
    endproperty
    a_sel_plain: assert property (p_sel_plain) else $error("unmodified ratio wrong");

    property p_manual_div16;
        (man_act && !auto_act && modal_sel.man_sel == 2'h3)
            |=> ratio_out.ratio == ($past(sel_ratio) >> 4);
    endproperty
    a_manual_div16: assert property (p_manual_div16) else $error("manual shift wrong");

    property p_manual_off;
        (glob_q.aux_func != 3'h3 || !aux_s)
            |=> ratio_out.ratio == ($past(sel_ratio) >> $past(auto_shift));
    endproperty
    a_manual_off: assert property (p_manual_off) else $error("manual active off pin");

    property p_auto_pin_low;
        (glob_q.aux_func == 3'h5 && !aux_s && range_code == 2'h2)
            |=> ratio_out.ratio == $past(sel_ratio);
    endproperty
    a_auto_pin_low: assert property (p_auto_pin_low) else $error("auto not overridden");

    property p_auto_modal;
        (glob_q.aux_func != 3'h5 && modal_sel.auto_en && !man_act && range_code == 2'h1)
            |=> ratio_out.ratio == ($past(sel_ratio) >> 1);
    endproperty
    a_auto_modal: assert property (p_auto_modal) else $error("modal auto wrong");

    property p_stack;
        (man_act && auto_act && range_code == 2'h2 && modal_sel.man_sel == 2'h1)
            |=> ratio_out.ratio == ($past(sel_ratio) >> 4);
    endproperty
    a_stack: assert property (p_stack) else $error("factors not combined");

    property p_fmt_split;
        glob_q.fmt |=> ratio_out.fmt && (ratio_out.int_part == ratio_out.ratio[31:12]);
    endproperty
    a_fmt_split: assert property (p_fmt_split) else $error("20.12 split wrong");

    property p_store_kept;
        !wr_en |=> ratio_flat == $past(ratio_flat);
    endproperty
    a_store_kept: assert property (p_store_kept) else $error("stored ratio changed");

    property p_hold;
        // compared with the past input, not the past output: the output is zero in reset
        $stable(eff_d) |=> ratio_out.ratio == $past(eff_d);
    endproperty
    a_hold: assert property (p_hold) else $error("ratio not held");

    sequence s_unlocked;
        !locked_s && !glob_q.out_unl;
    endsequence
    property p_unlock_low;
        s_unlocked |=> !gate_q;
    endproperty
    a_unlock_low: assert property (p_unlock_low) else $error("clock not gated when unlocked");

    property p_unlock_pass;
        glob_q.out_unl |=> gate_q;
    endproperty
    a_unlock_pass: assert property (p_unlock_pass) else $error("clock gated despite unlock option");

    property p_out_disable;
        (aux_s && glob_q.aux_func == 3'h2) |=> !synth_clk_oe;
    endproperty
    a_out_disable: assert property (p_out_disable) else $error("output not disabled");

    property p_out_enable;
        !aux_s |=> synth_clk_oe;
    endproperty
    a_out_enable: assert property (p_out_enable) else $error("output not enabled");

    sequence s_rd_status;
        rd_req && haddr[7:0] == 8'h18;
    endsequence
    property p_rd_status;
        s_rd_status |=> hrdata[1:0] == $past(range_code);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read wrong");
endmodule

// [dv/prsl_ref_src.sv]
`timescale 1ns/10ps
module prsl_ref_src (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // reference period in hclk cycles
    input  wire logic [8:0] period,
    // frequency reference output
    output logic            freq_ref_in
);
    logic [8:0] cnt_q;

    // the reference runs free; a period change takes effect at once, in the current period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q       <= 9'h0;
            freq_ref_in <= 1'b0;
        end else begin
            cnt_q       <= (cnt_q >= period - 9'h1) ? 9'h0 : cnt_q + 9'h1;
            freq_ref_in <= (cnt_q < {1'b0, period[8:1]});
        end
    end
endmodule

// [dv/test_pll_ratio_select_logic.sv]
`timescale 1ns/10ps
module test_pll_ratio_select_logic;
    import prsl_pkg::*;
    logic            hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0]     haddr, hwdata, hrdata, rd;
    logic [1:0]      htrans, pins;
    logic [2:0]      hsize;
    logic            aux_mode_pin, freq_ref_in, loop_locked;
    logic            synth_clk_in, synth_clk_out, synth_clk_oe, ratio_changed;
    logic [8:0]      period;
    prsl_ratio_out_t ratio_out;
    int              mismatches, num_checks, cycles;
    // all below 4096 in 12.20, low zeros so no shift truncates
    logic [31:0]     rv [4] = '{32'h0200_0000, 32'h0123_4540, 32'h0ff0_0000, 32'h0001_8000};

    assign hready = hreadyout;

    prsl_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ratio_select_pins(pins), .aux_mode_pin(aux_mode_pin),
        .freq_ref_in(freq_ref_in), .loop_locked(loop_locked), .synth_clk_in(synth_clk_in),
        .synth_clk_out(synth_clk_out), .synth_clk_oe(synth_clk_oe), .ratio_out(ratio_out),
        .ratio_changed(ratio_changed));

    prsl_ref_src ref_src (.hclk(hclk), .hresetn(hresetn), .period(period), .freq_ref_in(freq_ref_in));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task automatic complete_run;
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hang guard, well above the longest expected run
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic settle;
        repeat (6) @(posedge hclk);
        #1;
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        hsize  <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, {31'h0, PRSL_RESP_OKAY});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
        settle();
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    task automatic pin(input logic [1:0] m, input logic a);
        @(posedge hclk);
        pins         <= m;
        aux_mode_pin <= a;
        settle();
    endtask

    task automatic t_reset;
        settle();
        chk("eff_rst", ratio_out.ratio, PRSL_RATIO_RST);
        chk("int_rst", ratio_out.int_part, 32'h1);
        rdchk("global", PRSL_OFS_GLOBAL, 32'h0);
        rdchk("ratio3", PRSL_OFS_RATIO3, PRSL_RATIO_RST);
        rdchk("unmapped", 8'h40, 32'h0);
    endtask

    task automatic t_select;
        ahb(1'b1, PRSL_OFS_RATIO0, rv[0]);
        @(posedge hclk);
        #1;
        chk("eff_next", ratio_out.ratio, rv[0]);
        chk("chg_pulse", {31'h0, ratio_changed}, 32'h1);
        @(posedge hclk);
        #1;
        chk("chg_end", {31'h0, ratio_changed}, 32'h0);
        for (int i = 1; i < 4; i++) wr(PRSL_OFS_RATIO0 + 8'(i * 4), rv[i]);
        for (int i = 0; i < 4; i++) begin
            pin(2'(i), 1'b0);
            chk("sel", ratio_out.ratio, rv[i]);
            chk("chg", {31'h0, ratio_changed}, 32'h0);
        end
    endtask

    task automatic t_format;
        pin(2'd1, 1'b0);
        wr(PRSL_OFS_GLOBAL, 32'h41);
        chk("fmt", {31'h0, ratio_out.fmt}, 32'h1);
        chk("int20", ratio_out.int_part, 32'h01234);
        chk("frac12", ratio_out.frac_part, 32'h54000);
        chk("plain", ratio_out.ratio, rv[1]);
        chk("rdiv", ratio_out.ref_div, 32'h2);
        wr(PRSL_OFS_GLOBAL, 32'h0);
        chk("int12", ratio_out.int_part, 32'h012);
        chk("frac20", ratio_out.frac_part, 32'h34540);
    endtask

    task automatic t_manual;
        pin(2'd0, 1'b1);
        chk("man_off", ratio_out.ratio, rv[0]);
        wr(PRSL_OFS_GLOBAL, 32'h6);
        for (int s = 0; s < 4; s++) begin
            wr(PRSL_OFS_MODAL, 32'(s));
            chk("man", ratio_out.ratio, rv[0] >> (s + 1));
        end
        pin(2'd0, 1'b0);
        chk("man_low", ratio_out.ratio, rv[0]);
        rdchk("stored", PRSL_OFS_RATIO0, rv[0]);
    endtask

    task automatic t_auto;
        logic [8:0] per [4] = '{9'd225, 9'd224, 9'd96, 9'd95};
        logic [1:0] code [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
        pin(2'd1, 1'b0);
        wr(PRSL_OFS_GLOBAL, 32'h0);
        wr(PRSL_OFS_MODAL, 32'h20);
        for (int k = 0; k < 4; k++) begin
            @(posedge hclk);
            period <= per[k];
            repeat (1000) @(posedge hclk);
            ahb(1'b0, PRSL_OFS_STATUS, 32'h0);
            chk("range", rd[1:0], code[k]);
            chk("auto", ratio_out.ratio, rv[1] >> code[k]);
        end
        wr(PRSL_OFS_GLOBAL, 32'h6);
        wr(PRSL_OFS_MODAL, 32'h28);
        pin(2'd1, 1'b1);
        chk("stack", ratio_out.ratio, rv[1] >> 4);
        pin(2'd0, 1'b1);
        chk("modal0", ratio_out.ratio, rv[0] >> 1);
        wr(PRSL_OFS_GLOBAL, 32'ha);
        wr(PRSL_OFS_MODAL, 32'h0);
        pin(2'd1, 1'b1);
        chk("pin_on", ratio_out.ratio, rv[1] >> 2);
        wr(PRSL_OFS_MODAL, 32'h20);
        pin(2'd1, 1'b0);
        chk("pin_off", ratio_out.ratio, rv[1]);
    endtask

    task automatic t_output;
        logic [2:0] fn [3] = '{3'h0, 3'h2, 3'h3};
        wr(PRSL_OFS_GLOBAL, 32'h0);
        @(posedge hclk);
        loop_locked <= 1'b0;
        settle();
        chk("unl_low", {31'h0, synth_clk_out}, 32'h0);
        wr(PRSL_OFS_GLOBAL, 32'h10);
        chk("unl_pass", {31'h0, synth_clk_out}, 32'h1);
        @(posedge hclk);
        loop_locked <= 1'b1;
        for (int f = 0; f < 3; f++) begin
            wr(PRSL_OFS_GLOBAL, {28'h0, fn[f], 1'b0});
            pin(2'd0, 1'b1);
            chk("oe_high", {31'h0, synth_clk_oe}, {31'h0, fn[f] == 3'h3});
            pin(2'd0, 1'b0);
            chk("oe_low", {31'h0, synth_clk_oe}, 32'h1);
            chk("locked", {31'h0, synth_clk_out}, 32'h1);
        end
    endtask

    initial begin
        hresetn      = 1'b0;
        hsel         = 1'b0;
        haddr        = 32'h0;
        htrans       = 2'h0;
        hwrite       = 1'b0;
        hsize        = 3'h2;
        hwdata       = 32'h0;
        pins         = 2'h0;
        aux_mode_pin = 1'b0;
        loop_locked  = 1'b1;
        synth_clk_in = 1'b1;
        period       = 9'd250;
        mismatches   = 0;
        num_checks   = 0;
        cycles       = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_select();
        t_format();
        t_manual();
        t_auto();
        t_output();
        complete_run();
    end
endmodule
